/* exec_pkg.sv */
// Shared constants for the return, rotate, subtract-with-borrow and skip execution slice.
// Assumes an 8-bit data path and a program counter held outside this slice.
package exec_pkg;

    // ============================================================
    // Widths
    localparam int DATA_W = 8;
    localparam int PC_W = 12;
    localparam int OP_W = 4;

    // ============================================================
    // Operation codes presented by the decoder
    localparam logic [OP_W-1:0] OP_SUBROUTINE_EXIT = 4'h0;
    localparam logic [OP_W-1:0] OP_RETURN_CONST = 4'h1;
    localparam logic [OP_W-1:0] OP_INTERRUPT_EXIT = 4'h2;
    localparam logic [OP_W-1:0] OP_ROTATE_LEFT_MEM = 4'h3;
    localparam logic [OP_W-1:0] OP_ROTATE_LEFT_TO_ACC = 4'h4;
    localparam logic [OP_W-1:0] OP_ROTATE_LEFT_THRU_CARRY = 4'h5;
    localparam logic [OP_W-1:0] OP_ROTATE_LEFT_CARRY_TO_ACC = 4'h6;
    localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_MEM = 4'h7;
    localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_TO_ACC = 4'h8;
    localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_THRU_CARRY = 4'h9;
    localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_CARRY_TO_ACC = 4'hA;
    localparam logic [OP_W-1:0] OP_SUBTRACT_WITH_BORROW = 4'hB;
    localparam logic [OP_W-1:0] OP_SUBTRACT_BORROW_TO_MEM = 4'hC;
    localparam logic [OP_W-1:0] OP_DECREMENT_SKIP_ZERO = 4'hD;
    localparam logic [OP_W-1:0] OP_DECREMENT_TO_ACC_SKIP_ZERO = 4'hE;

    // ============================================================
    // Reset values
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;

    // ============================================================
    // Bit positions
    localparam int MSB = 7;
    localparam int NIB_MSB = 3;

    // ============================================================
    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DUMMY = 2'b10
    } exec_state_t;

    // Rotate a byte left by one, fill entering bit 0.
    function automatic logic [DATA_W-1:0] rot_left(input logic [DATA_W-1:0] v, input logic fill);
        rot_left = {v[MSB-1:0], fill};
    endfunction : rot_left

    // Rotate a byte right by one, fill entering bit 7.
    function automatic logic [DATA_W-1:0] rot_right(input logic [DATA_W-1:0] v, input logic fill);
        rot_right = {fill, v[MSB:1]};
    endfunction : rot_right

endpackage : exec_pkg

/* alu_if.sv */
// Carrier between the execution sequencer and its combinational arithmetic unit.
// Assumes both ends run in one clock domain; the unit holds no state.
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
    import exec_pkg::*;

    // Operands.
    logic [OP_W-1:0] op;
    logic [DATA_W-1:0] mem;
    logic [DATA_W-1:0] imm;
    logic carry;

    // Results.
    logic [DATA_W-1:0] result;
    logic to_acc;
    logic to_mem;
    logic upd_carry;
    logic upd_arith;
    logic new_carry;
    logic new_ov;
    logic new_zero;
    logic new_half;
    logic pop;
    logic gie_set;
    logic two_cycle;
    logic skip;

    modport ctrl (output op, mem, imm, carry,
                  input result, to_acc, to_mem, upd_carry, upd_arith, new_carry, new_ov, new_zero, new_half,
                  pop, gie_set, two_cycle, skip);
    modport unit (input op, mem, imm, carry,
                  output result, to_acc, to_mem, upd_carry, upd_arith, new_carry, new_ov, new_zero, new_half,
                  pop, gie_set, two_cycle, skip);
endinterface : alu_if
`default_nettype wire

/* alu_unit.sv */
// Combinational result and flag generation for one instruction.
// Assumes the accumulator value arrives through the acc_in port for the subtract forms.
`timescale 1ns/1ps
`default_nettype none
module alu_unit (
    // Operands in, results out.
    alu_if.unit bus,
    // Current accumulator.
    input wire logic [exec_pkg::DATA_W-1:0] acc_in
);
    import exec_pkg::*;

    // ============================================================
    // Arithmetic
    // Subtract with borrow is an add of the inverted operand plus the carry, so C set means no borrow.
    wire [DATA_W:0] sub_sum = {1'b0, acc_in} + {1'b0, ~bus.mem} + {8'h00, bus.carry};
    wire [NIB_MSB+1:0] sub_low = {1'b0, acc_in[NIB_MSB:0]} + {1'b0, ~bus.mem[NIB_MSB:0]} + {4'h0, bus.carry};
    wire sub_ov = (acc_in[MSB] == ~bus.mem[MSB]) && (sub_sum[MSB] != acc_in[MSB]);
    wire [DATA_W-1:0] dec_val = bus.mem - 8'h01;
    wire is_sub = (bus.op == OP_SUBTRACT_WITH_BORROW) || (bus.op == OP_SUBTRACT_BORROW_TO_MEM);
    wire is_dec = (bus.op == OP_DECREMENT_SKIP_ZERO) || (bus.op == OP_DECREMENT_TO_ACC_SKIP_ZERO);
    wire is_ret = (bus.op == OP_SUBROUTINE_EXIT) || (bus.op == OP_RETURN_CONST) || (bus.op == OP_INTERRUPT_EXIT);

    // ============================================================
    // Result selection.
    always_comb
    begin
        case (bus.op)
            OP_RETURN_CONST: bus.result = bus.imm;
            OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_TO_ACC: bus.result = rot_left(bus.mem, bus.mem[MSB]);
            OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_CARRY_TO_ACC: bus.result = rot_left(bus.mem, bus.carry);
            OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_TO_ACC: bus.result = rot_right(bus.mem, bus.mem[0]);
            OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_RIGHT_CARRY_TO_ACC: bus.result = rot_right(bus.mem, bus.carry);
            OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_BORROW_TO_MEM: bus.result = sub_sum[DATA_W-1:0];
            OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_TO_ACC_SKIP_ZERO: bus.result = dec_val;
            default: bus.result = 8'h00;
        endcase
    end

    // Destination and flag steering; memory forms write back, accumulator forms leave memory alone.
    assign bus.to_acc = (bus.op == OP_RETURN_CONST) || (bus.op == OP_ROTATE_LEFT_TO_ACC)
        || (bus.op == OP_ROTATE_LEFT_CARRY_TO_ACC) || (bus.op == OP_ROTATE_RIGHT_TO_ACC)
        || (bus.op == OP_ROTATE_RIGHT_CARRY_TO_ACC) || (bus.op == OP_SUBTRACT_WITH_BORROW)
        || (bus.op == OP_DECREMENT_TO_ACC_SKIP_ZERO);
    assign bus.to_mem = (bus.op == OP_ROTATE_LEFT_MEM) || (bus.op == OP_ROTATE_LEFT_THRU_CARRY)
        || (bus.op == OP_ROTATE_RIGHT_MEM) || (bus.op == OP_ROTATE_RIGHT_THRU_CARRY)
        || (bus.op == OP_SUBTRACT_BORROW_TO_MEM) || (bus.op == OP_DECREMENT_SKIP_ZERO);
    assign bus.upd_carry = (bus.op == OP_ROTATE_LEFT_THRU_CARRY) || (bus.op == OP_ROTATE_LEFT_CARRY_TO_ACC)
        || (bus.op == OP_ROTATE_RIGHT_THRU_CARRY) || (bus.op == OP_ROTATE_RIGHT_CARRY_TO_ACC) || is_sub;
    assign bus.upd_arith = is_sub;
    assign bus.new_carry = is_sub ? sub_sum[DATA_W]
        : ((bus.op == OP_ROTATE_LEFT_THRU_CARRY) || (bus.op == OP_ROTATE_LEFT_CARRY_TO_ACC)) ? bus.mem[MSB]
        : bus.mem[0];
    assign bus.new_ov = sub_ov;
    assign bus.new_zero = (sub_sum[DATA_W-1:0] == 8'h00);
    assign bus.new_half = sub_low[NIB_MSB+1];
    assign bus.pop = is_ret;
    assign bus.gie_set = (bus.op == OP_INTERRUPT_EXIT);
    assign bus.skip = is_dec && (dec_val == 8'h00);
    assign bus.two_cycle = is_ret || bus.skip;

endmodule : alu_unit
`default_nettype wire

/* exec_slice.sv */
// Execution slice for returns, rotates, subtract-with-borrow and decrement-skip-if-zero.
// Assumes the decoder presents one operation with its memory operand already read,
// and that stack, program counter register and data memory live outside and act on the strobes.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Subroutine exit pops the program counter from the stack; two cycles.
// - Return-with-constant pops the program counter and loads the accumulator with the constant.
// - Rotate left through carry on memory: bit 7 to carry, old carry to bit 0.
// - Accumulator form of rotate left through carry updates carry, leaves memory unchanged.
// - Plain rotate right on memory moves bit 0 to bit 7 and writes back.
// - Accumulator form of plain rotate right puts the result in the accumulator only.
// - Rotate right through carry on memory: bit 0 to carry, old carry to bit 7.
// - Subtract with borrow adds acc, inverted memory and carry; updates four flags.
// - Decrement-skip writes back; a zero result adds a dummy cycle discarding the prefetch.
// - Accumulator form of decrement-skip keeps memory, loads acc, skips on zero.
module exec_slice (
    // Clock, reset and enable.
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // Operation request.
    input wire logic op_valid_in,
    input wire logic [exec_pkg::OP_W-1:0] op_code_in,
    input wire logic [exec_pkg::DATA_W-1:0] imm_in,
    input wire logic [exec_pkg::DATA_W-1:0] mem_rdata_in,
    // Value at the top of the return stack.
    input wire logic [exec_pkg::PC_W-1:0] stack_pc_in,
    // Sequencing.
    output logic ready_out,
    output logic done_out,
    output logic skip_out,
    // Program counter and stack.
    output logic stack_pop_out,
    output logic pc_load_out,
    output logic [exec_pkg::PC_W-1:0] pc_value_out,
    output logic gie_set_out,
    // Data memory write back.
    output logic mem_we_out,
    output logic [exec_pkg::DATA_W-1:0] mem_wdata_out,
    // Accumulator and flags.
    output logic [exec_pkg::DATA_W-1:0] acc_out,
    output logic carry_flag_out,
    output logic sign_error_flag_out,
    output logic zero_flag_out,
    output logic half_carry_flag_out
);
    import exec_pkg::*;

    // ============================================================
    // State
    // One register per output, with pop_q driving both the stack pop and the program counter load, so every pin comes straight from a flip-flop.
    exec_state_t state_q;
    exec_state_t state_d;
    logic ready_q;
    logic done_q;
    logic skip_q;
    logic pop_q;
    logic [PC_W-1:0] pc_q;
    logic gie_q;
    logic mem_we_q;
    logic [DATA_W-1:0] mem_wdata_q;
    logic [DATA_W-1:0] acc_q;
    logic carry_q;
    logic ov_q;
    logic zero_q;
    logic half_q;

    // The unit is purely combinational; it sees the request as it stands in the take cycle.
    alu_if alu_bus();

    // ============================================================
    // Arithmetic unit
    assign alu_bus.op = op_code_in;
    assign alu_bus.mem = mem_rdata_in;
    assign alu_bus.imm = imm_in;
    // The carry operand is the registered flag, so back-to-back requests see the previous result.
    assign alu_bus.carry = carry_q;

    alu_unit u_alu (
        .bus(alu_bus.unit),
        .acc_in(acc_q)
    );

    // ============================================================
    // Decode of the request
    // An operation is taken only while idle, so two-cycle operations hold off the next one.
    // A low enable blocks the take as well, so a standing request is delayed, never lost.
    wire take = ce_in && op_valid_in && (state_q == ST_IDLE);
    wire take_long = take && alu_bus.two_cycle;
    wire take_short = take && !alu_bus.two_cycle;
    wire in_dummy = ce_in && (state_q == ST_DUMMY);

    // Next sequencer state.
    always_comb
    begin
        case (state_q)
            ST_IDLE: state_d = take_long ? ST_DUMMY : ST_IDLE;
            ST_DUMMY: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // Sequencer and handshake; the dummy cycle is where the prefetched word is thrown away.
    // Ready mirrors the idle state so the core need not decode the one-hot word itself.
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            done_q <= 1'b0;
        end
        else if (ce_in)
        begin
            state_q <= state_d;
            ready_q <= !take_long;
            done_q <= take_short || in_dummy;
        end
    end

    // ============================================================
    // Side-effect strobes, each one cycle wide at the edge after the request is taken.
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            pop_q <= 1'b0;
            gie_q <= 1'b0;
            skip_q <= 1'b0;
            mem_we_q <= 1'b0;
        end
        else if (ce_in)
        begin
            pop_q <= take && alu_bus.pop;
            gie_q <= take && alu_bus.gie_set;
            skip_q <= take && alu_bus.skip;
            mem_we_q <= take && alu_bus.to_mem;
        end
    end

    // Data held alongside the strobes; they only matter while the matching strobe is high.
    // Capturing on every take toggles a few flops needlessly but keeps the enable to one term.
    // The write data reset value never reaches memory, since the write strobe is low then.
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            pc_q <= PC_RESET;
            mem_wdata_q <= 8'h00;
        end
        else if (take)
        begin
            pc_q <= stack_pc_in;
            mem_wdata_q <= alu_bus.result;
        end
    end

    // ============================================================
    // Accumulator and flags
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            acc_q <= ACC_RESET;
        end
        else if (take && alu_bus.to_acc)
        begin
            acc_q <= alu_bus.result;
        end
    end

    // Plain rotates and decrements leave every flag as it was.
    // Carry has its own enable because the rotates through carry touch carry alone.
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            carry_q <= FLAG_RESET;
            ov_q <= FLAG_RESET;
            zero_q <= FLAG_RESET;
            half_q <= FLAG_RESET;
        end
        else if (take)
        begin
            if (alu_bus.upd_carry)
            begin
                carry_q <= alu_bus.new_carry;
            end
            if (alu_bus.upd_arith)
            begin
                ov_q <= alu_bus.new_ov;
                zero_q <= alu_bus.new_zero;
                half_q <= alu_bus.new_half;
            end
        end
    end

    // ============================================================
    // Outputs, all straight from flip-flops.
    // While the enable is low a pulse stretches with the frozen state; the core must gate on it too.
    assign ready_out = ready_q;
    assign done_out = done_q;
    assign skip_out = skip_q;
    assign stack_pop_out = pop_q;
    assign pc_load_out = pop_q;
    assign pc_value_out = pc_q;
    assign gie_set_out = gie_q;
    assign mem_we_out = mem_we_q;
    assign mem_wdata_out = mem_wdata_q;
    assign acc_out = acc_q;
    assign carry_flag_out = carry_q;
    assign sign_error_flag_out = ov_q;
    assign zero_flag_out = zero_q;
    assign half_carry_flag_out = half_q;

endmodule : exec_slice
`default_nettype wire

/* exec_slice_sva.sv */
// Checker for the execution slice: timing and results of exits, rotates, subtract and decrement-skip.
// Assumes it is bound to exec_slice and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module exec_slice_chk (
    // Clock, reset and request.
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic op_valid_in,
    input wire logic [exec_pkg::OP_W-1:0] op_code_in,
    input wire logic [exec_pkg::DATA_W-1:0] imm_in,
    input wire logic [exec_pkg::DATA_W-1:0] mem_rdata_in,
    input wire logic [exec_pkg::PC_W-1:0] stack_pc_in,
    // Watched outputs.
    input wire logic ready_out,
    input wire logic done_out,
    input wire logic skip_out,
    input wire logic stack_pop_out,
    input wire logic [exec_pkg::PC_W-1:0] pc_value_out,
    input wire logic gie_set_out,
    input wire logic mem_we_out,
    input wire logic [exec_pkg::DATA_W-1:0] mem_wdata_out,
    input wire logic [exec_pkg::DATA_W-1:0] acc_out,
    input wire logic carry_flag_out,
    input wire logic zero_flag_out
);
    import exec_pkg::*;
    // ========================================
    // One bit per operation code, high in the cycle a request is taken.
    wire logic [15:0] tk = (ce_in && op_valid_in && ready_out) ? (16'h0001 << op_code_in) : 16'h0000;
    logic [DATA_W-1:0] mem_q;
    logic [DATA_W-1:0] acc_q;
    logic carry_q;

    // Operands as seen at the take edge; slices of $past results are not legal, hence copies.
    always_ff @(posedge clk_sys_in)
    begin
        mem_q <= mem_rdata_in;
        acc_q <= acc_out;
        carry_q <= carry_flag_out;
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);

    // ========================================
    // Results one cycle after the take edge.
    exit_two_cycle_a:
        assert property (tk[OP_SUBROUTINE_EXIT] |=> stack_pop_out && !ready_out && !done_out
            && pc_value_out == $past(stack_pc_in) ##1 done_out && ready_out) else $error("exit timing wrong");
    exit_const_a:
        assert property (tk[OP_RETURN_CONST] |=> stack_pop_out && acc_out == $past(imm_in))
            else $error("return constant wrong");
    rot_left_mem_a:
        assert property (tk[OP_ROTATE_LEFT_MEM] |=> mem_we_out && mem_wdata_out == {mem_q[6:0], mem_q[7]}
            && $stable(carry_flag_out)) else $error("rotate left wrong");
    rot_left_carry_a:
        assert property (tk[OP_ROTATE_LEFT_THRU_CARRY] |=> mem_we_out && carry_flag_out == mem_q[7]
            && mem_wdata_out == {mem_q[6:0], carry_q}) else $error("rotate left carry wrong");
    rot_right_acc_a:
        assert property (tk[OP_ROTATE_RIGHT_TO_ACC] |=> !mem_we_out && acc_out == {mem_q[0], mem_q[7:1]})
            else $error("rotate right to acc wrong");
    rot_right_cacc_a:
        assert property (tk[OP_ROTATE_RIGHT_CARRY_TO_ACC] |=> !mem_we_out && carry_flag_out == mem_q[0]
            && acc_out == {carry_q, mem_q[7:1]}) else $error("rotate right carry to acc wrong");
    sub_borrow_a:
        assert property (tk[OP_SUBTRACT_WITH_BORROW] |=> acc_out == acc_q + ~mem_q + carry_q
            && zero_flag_out == (acc_out == 8'h00) && !mem_we_out) else $error("subtract wrong");
    dec_skip_zero_a:
        assert property (tk[OP_DECREMENT_SKIP_ZERO] && mem_rdata_in == 8'h01 |=> skip_out && mem_we_out
            && mem_wdata_out == 8'h00 && !done_out ##1 done_out && ready_out) else $error("skip timing wrong");
    exit_gie_set_a:
        assert property (tk[OP_INTERRUPT_EXIT] |=> stack_pop_out && gie_set_out
            && pc_value_out == $past(stack_pc_in)) else $error("interrupt exit wrong");
    dec_acc_skip_a:
        assert property (tk[OP_DECREMENT_TO_ACC_SKIP_ZERO] |=> !mem_we_out && acc_out == mem_q - 8'h01
            && skip_out == (mem_q == 8'h01)) else $error("decrement to acc wrong");
    // A low enable must hold the accumulator, carry and handshake where they are.
    ce_freeze_a:
        assert property (!ce_in |=> $stable(acc_out) && $stable(ready_out) && $stable(carry_flag_out))
            else $error("state moved while frozen");
endmodule : exec_slice_chk

bind exec_slice exec_slice_chk i_exec_slice_chk (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce_in), .op_valid_in(op_valid_in),
    .op_code_in(op_code_in), .imm_in(imm_in), .mem_rdata_in(mem_rdata_in), .stack_pc_in(stack_pc_in),
    .ready_out(ready_out), .done_out(done_out), .skip_out(skip_out), .stack_pop_out(stack_pop_out),
    .pc_value_out(pc_value_out), .gie_set_out(gie_set_out), .mem_we_out(mem_we_out),
    .mem_wdata_out(mem_wdata_out), .acc_out(acc_out), .carry_flag_out(carry_flag_out),
    .zero_flag_out(zero_flag_out)
);
`default_nettype wire

/* exec_slice_tb.sv */
// Self-checking bench for the execution slice: exits, rotates, subtract with borrow, decrement-skip.
// Assumes exec_pkg, the design and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module exec_slice_tb;
    import exec_pkg::*;
    // ========================================
    // Stimulus, observed outputs and bookkeeping.
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic ce_in = 1'b1;
    logic op_valid_in = 1'b0;
    logic [OP_W-1:0] op_code_in = 4'hF;
    logic [DATA_W-1:0] imm_in = 8'h00;
    logic [DATA_W-1:0] mem_rdata_in = 8'h00;
    logic [PC_W-1:0] stack_pc_in = 12'h000;
    logic ready_out, done_out, skip_out, stack_pop_out, pc_load_out, gie_set_out, mem_we_out;
    logic carry_flag_out, sign_error_flag_out, zero_flag_out, half_carry_flag_out;
    logic [PC_W-1:0] pc_value_out;
    logic [DATA_W-1:0] mem_wdata_out, acc_out;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [DATA_W-1:0] ea = 8'h00; // Expected accumulator.
    logic ec = 1'b0; // Expected carry.

    exec_slice i_exec_slice (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce_in), .op_valid_in(op_valid_in),
        .op_code_in(op_code_in), .imm_in(imm_in), .mem_rdata_in(mem_rdata_in), .stack_pc_in(stack_pc_in),
        .ready_out(ready_out), .done_out(done_out), .skip_out(skip_out), .stack_pop_out(stack_pop_out),
        .pc_load_out(pc_load_out), .pc_value_out(pc_value_out), .gie_set_out(gie_set_out),
        .mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out), .acc_out(acc_out),
        .carry_flag_out(carry_flag_out), .sign_error_flag_out(sign_error_flag_out),
        .zero_flag_out(zero_flag_out), .half_carry_flag_out(half_carry_flag_out)
    );

    // Clock, and a cycle ceiling well above the fewer than a hundred cycles the run needs.
    initial
        forever #5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Present one request for a cycle; returns in the cycle after the take edge.
    task automatic issue(input logic [3:0] c, input logic [7:0] m, input logic [7:0] i);
        @(negedge clk_sys_in);
        op_valid_in = 1'b1;
        op_code_in = c;
        mem_rdata_in = m;
        imm_in = i;
        stack_pc_in = {i, c};
        @(negedge clk_sys_in);
        op_valid_in = 1'b0;
        mem_rdata_in = ~m; // Operands only count at the take edge.
    endtask : issue

    // ========================================
    // The three exits: pop, reload, two cycles.
    task automatic t_exits();
        for (int k = 0; k < 3; k++)
        begin
            issue(k[3:0], 8'h00, 8'hA5 ^ k[7:0]);
            if (k == 1)
                ea = 8'hA5 ^ k[7:0];
            chk({stack_pop_out, pc_load_out, ready_out, done_out}, 4'hC);
            chk(pc_value_out, {8'hA5 ^ k[7:0], k[3:0]});
            chk(gie_set_out, k == 2);
            chk(acc_out, ea);
            @(negedge clk_sys_in);
            chk({ready_out, done_out, stack_pop_out}, 3'b110);
        end
    endtask : t_exits

    // All eight rotate forms on one byte, carry tracked across them.
    task automatic t_rotates(input logic [7:0] m);
        logic [7:0] r;
        logic f;
        for (int c = 3; c <= 10; c++)
        begin
            f = (c inside {5, 6, 9, 10}) ? ec : (c < 7 ? m[7] : m[0]);
            r = (c < 7) ? {m[6:0], f} : {f, m[7:1]};
            if (c inside {5, 6, 9, 10})
                ec = (c < 7) ? m[7] : m[0];
            if (!c[0])
                ea = r;
            issue(c[3:0], m, 8'h00);
            chk({mem_we_out, done_out}, {c[0], 1'b1});
            chk(c[0] ? mem_wdata_out : acc_out, r);
            chk(acc_out, ea);
            chk(carry_flag_out, ec);
        end
    endtask : t_rotates

    // Subtract with borrow after loading the accumulator through a return with constant.
    task automatic t_sbc(input logic [7:0] a, input logic [7:0] m, input logic cm);
        logic [8:0] s;
        logic [4:0] h;
        logic [3:0] fl;
        issue(OP_RETURN_CONST, 8'h00, a);
        s = {1'b0, a} + {1'b0, ~m} + ec;
        h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + ec;
        ea = cm ? a : s[7:0];
        ec = s[8];
        issue(cm ? OP_SUBTRACT_BORROW_TO_MEM : OP_SUBTRACT_WITH_BORROW, m, 8'h00);
        fl = {(a[7] != m[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
        chk({mem_we_out, acc_out}, {cm, ea});
        chk(cm ? mem_wdata_out : acc_out, s[7:0]);
        chk({sign_error_flag_out, zero_flag_out, half_carry_flag_out, carry_flag_out}, fl);
    endtask : t_sbc

    // Decrement-skip in both forms; a zero result adds the dummy cycle.
    task automatic t_dec(input logic [3:0] c, input logic [7:0] m);
        logic [7:0] d;
        logic z;
        d = m - 8'h01;
        z = (d == 8'h00);
        if (c == OP_DECREMENT_TO_ACC_SKIP_ZERO)
            ea = d;
        issue(c, m, 8'h00);
        chk(mem_we_out, c == OP_DECREMENT_SKIP_ZERO);
        chk(c == OP_DECREMENT_SKIP_ZERO ? mem_wdata_out : acc_out, d);
        chk(acc_out, ea);
        chk({skip_out, done_out, ready_out}, z ? 3'b100 : 3'b011);
        if (z)
        begin
            @(negedge clk_sys_in);
            chk({skip_out, done_out, ready_out}, 3'b011);
        end
    endtask : t_dec

    // Enable low: a standing request is held off, then taken once the enable returns.
    task automatic t_freeze();
        @(negedge clk_sys_in);
        ce_in = 1'b0;
        op_valid_in = 1'b1;
        op_code_in = OP_ROTATE_RIGHT_TO_ACC;
        mem_rdata_in = 8'h3C;
        repeat (2) @(negedge clk_sys_in);
        chk({done_out, mem_we_out, acc_out}, {2'h0, ea});
        ce_in = 1'b1;
        ea = 8'h1E;
        @(negedge clk_sys_in);
        op_valid_in = 1'b0;
        chk({done_out, acc_out}, {1'h1, ea});
    endtask : t_freeze

    // Reset in the second cycle of an interrupt exit returns every output to its reset value.
    task automatic t_reset();
        issue(OP_INTERRUPT_EXIT, 8'h00, 8'h5A);
        chk({gie_set_out, stack_pop_out}, 2'h3);
        srst_in = 1'b1;
        @(negedge clk_sys_in);
        srst_in = 1'b0;
        ea = ACC_RESET;
        ec = FLAG_RESET;
        chk({ready_out, done_out, stack_pop_out, gie_set_out, mem_we_out, skip_out}, 6'h20);
        chk(acc_out, ACC_RESET);
        chk(pc_value_out, PC_RESET);
        chk(mem_wdata_out, 8'h00);
        chk({carry_flag_out, sign_error_flag_out, zero_flag_out, half_carry_flag_out}, {4{FLAG_RESET}});
    endtask : t_reset

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // ========================================
    // Main sequence.
    initial
    begin
        repeat (12) @(negedge clk_sys_in);
        srst_in = 1'b0;
        chk({ready_out, acc_out}, {1'b1, ACC_RESET});
        t_exits();
        t_rotates(8'h96);
        t_rotates(8'h69);
        t_sbc(8'h50, 8'h30, 1'b0);
        t_sbc(8'h80, 8'h01, 1'b1);
        t_sbc(8'h10, 8'h10, 1'b0);
        t_sbc(8'h00, 8'h01, 1'b1);
        t_dec(OP_DECREMENT_SKIP_ZERO, 8'h01);
        t_dec(OP_DECREMENT_SKIP_ZERO, 8'h00);
        t_dec(OP_DECREMENT_TO_ACC_SKIP_ZERO, 8'h01);
        t_dec(OP_DECREMENT_TO_ACC_SKIP_ZERO, 8'h05);
        t_freeze();
        t_reset();
        t_dec(OP_DECREMENT_TO_ACC_SKIP_ZERO, 8'h02);
        end_of_test();
    end
endmodule : exec_slice_tb
`default_nettype wire
